// File: core/eeprom_protect_regs.svh
// Constants for the serial EEPROM write-protection block.
`ifndef EEPROM_PROTECT_REGS_SVH
`define EEPROM_PROTECT_REGS_SVH
`define OP_SET_LATCH 8'h06
`define OP_CLR_LATCH 8'h04
`define OP_READ_STATUS 8'h05
`define OP_WRITE_STATUS 8'h01
`define OP_ARRAY_WRITE 8'h02
`define SR_PIN_EN_BIT 7
`define SR_BP_HI_BIT 3
`define SR_BP_LO_BIT 2
`define SR_LATCH_BIT 1
`define SR_BUSY_BIT 0
`define PROT_QUARTER_BASE 12'hc00
`define PROT_HALF_BASE 12'h800
`define ADDR_BITS 12
`define WRITE_CYCLE_NS 5000000
`define CLK_PERIOD_NS 25
`define WRITE_CYCLE_CLKS (`WRITE_CYCLE_NS / `CLK_PERIOD_NS)
`define STATUS_BITS_AFTER_OP 16
`define ARRAY_HDR_BITS 24
`endif

// File: core/eeprom_protect_pkg.sv
// Types for the serial EEPROM write-protection block.
package eeprom_protect_pkg;
    typedef enum logic [1:0] {IDLE_ST, ACTIVE_ST, BUSY_ST} state_type;
endpackage : eeprom_protect_pkg

// File: core/serial_eeprom_write_protect.sv
// Write-protect, status and latch logic of an SPI serial EEPROM.

`include "eeprom_protect_regs.svh"

// Design notes.
// The block runs entirely on i_clk. The host's serial clock, select, data and
// the protect pin are all treated as asynchronous and pass a two-stage
// synchroniser before any logic looks at them. Edges of the serial clock and
// of select are found by comparing the second stage with a delayed copy.
// Because of that, the host's serial clock must stay at least four system
// clocks high and four low; a faster host would lose bits.
//
// Commands take effect when select rises, never on a serial clock edge, so a
// host that aborts a frame early leaves the latch and the status bits alone.
// The bit counter wraps from 63 back to 32, in the top half of its range, which keeps the
// byte-boundary test valid for long page writes without a wide counter.
//
// The protect bits live in flip-flops here. A real part keeps them in the
// array; this block only models what the host can observe, so they return
// to zero on i_reset.
//
// The write cycle is a plain down-counter. Its length is a parameter so a
// simulation can use a short cycle; silicon uses the full programming time.
// While it runs, array and status writes are ignored, status reads and the
// set-latch command still work, and the clear-latch command is dropped
// because the end of the cycle clears the latch anyway.
//
// Refused requests are silent: a status write without the latch or under
// hardware protection, an array write into a locked block, without the latch,
// cut off between byte boundaries or issued during a cycle all leave every
// register as it was. The host learns of them only by reading the status.
//
// Opcodes other than the four register commands and the array write are
// shifted in and ignored; read data paths of the array are not part of this
// block.
//
// The serial output is only enabled during the data phase of a status read
// and is released whenever select is high.
module serial_eeprom_write_protect
    import eeprom_protect_pkg::*;
#(
    parameter int unsigned WRITE_CYCLE_CLKS = `WRITE_CYCLE_CLKS
)
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_reset,
    // SPI pins from the host.
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_sdi,
    input wire logic i_write_protect_n,
    // Serial data out, two signals; enable low means driven.
    output logic o_sdo,
    output logic o_sdo_oe_n,
    // Array write request to the programming engine.
    output logic o_array_write,
    output logic [`ADDR_BITS-1:0] o_array_addr,
    // Status view.
    output logic [7:0] o_status
);
    // Pin synchronisers; first stage read only by second.
    logic [1:0] cs_s_r, sck_s_r, sdi_s_r, wp_s_r;
    logic cs_q_r, sck_q_r;
    // Control state.
    state_type state_r;
    logic armed_r, latch_r, busy_r, pin_en_r, bp_hi_r, bp_lo_r;
    logic [5:0] bit_cnt_r;
    logic [7:0] opcode_r, shift_r, out_byte_r;
    logic [15:0] addr_r;
    logic [31:0] timer_r;
    logic sdo_r, sdo_oe_n_r, array_write_r;
    logic [`ADDR_BITS-1:0] array_addr_r;
    logic [7:0] status_r;

    // Protect pair decode.
    // Whether an address falls in a region the protect pair locks.
    // A function keeps the range decode in one place for every array write request.
    function automatic logic addr_locked(input logic hi, input logic lo, input logic [`ADDR_BITS-1:0] a);
        logic r;
        r = 1'b0;
        unique case ({hi, lo})
            2'b00: r = 1'b0;
            2'b01: r = (a >= `PROT_QUARTER_BASE);
            2'b10: r = (a >= `PROT_HALF_BASE);
            2'b11: r = 1'b1;
        endcase
        return r;
    endfunction : addr_locked

    // Edge decode on synchronised pins.
    wire cs_n = cs_s_r[1];
    wire sck_rise = sck_s_r[1] & ~sck_q_r;
    wire sck_fall = ~sck_s_r[1] & sck_q_r;
    wire cs_fall = ~cs_n & cs_q_r;
    wire cs_rise = cs_n & ~cs_q_r;
    wire sdi = sdi_s_r[1];
    wire [5:0] bits_in = bit_cnt_r + 6'h01;
    wire [7:0] shift_nxt = {shift_r[6:0], sdi};
    wire byte_done = (bit_cnt_r[2:0] == 3'h0) && (bit_cnt_r != 6'h00);
    wire hw_protect = ~wp_s_r[1] & pin_en_r;
    // Hardware protection blocks only status writes.
    // Status write needs the latch and no hardware protection.
    wire status_ok = latch_r & ~hw_protect;
    // Array write needs the latch and an unlocked address.
    wire array_ok = latch_r & ~addr_locked(bp_hi_r, bp_lo_r, addr_r[`ADDR_BITS-1:0]);
    // Write starts only when select rises on a byte boundary.
    wire stat_wr_go = (opcode_r == `OP_WRITE_STATUS) && (bit_cnt_r == `STATUS_BITS_AFTER_OP) && status_ok;
    wire arr_wr_go = (opcode_r == `OP_ARRAY_WRITE) && (bit_cnt_r > `ARRAY_HDR_BITS) && byte_done && array_ok;
    // Status composition; unused bits read zero.
    wire [7:0] status_now = {pin_en_r, 3'h0, bp_hi_r, bp_lo_r, latch_r, busy_r};

    // Synchronisers for every pin.
    // Reset values match the idle pin levels so no false edge follows reset.
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            cs_s_r <= 2'b11;
            sck_s_r <= 2'b00;
            sdi_s_r <= 2'b00;
            wp_s_r <= 2'b11;
            cs_q_r <= 1'b1;
            sck_q_r <= 1'b0;
        end
        else
        begin
            cs_s_r <= {cs_s_r[0], i_cs_n};
            sck_s_r <= {sck_s_r[0], i_sck};
            sdi_s_r <= {sdi_s_r[0], i_sdi};
            wp_s_r <= {wp_s_r[0], i_write_protect_n};
            cs_q_r <= cs_s_r[1];
            sck_q_r <= sck_s_r[1];
        end
    end

    // Serial shifter and command decode. Bits are sampled on SCK rise.
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            state_r <= IDLE_ST;
            armed_r <= 1'b0;
            bit_cnt_r <= 6'h00;
            opcode_r <= 8'h00;
            shift_r <= 8'h00;
            addr_r <= 16'h0000;
            out_byte_r <= 8'h00;
            sdo_r <= 1'b0;
            sdo_oe_n_r <= 1'b1;
        end
        else if (cs_n)
        begin
            sdo_oe_n_r <= 1'b1;
            bit_cnt_r <= 6'h00;
            // Select rising marks the host as seen deselected.
            if (cs_rise)
                armed_r <= 1'b1;
        end
        else if (cs_fall)
        begin
            // Stays inactive until a falling select after power-up.
            armed_r <= 1'b1;
            bit_cnt_r <= 6'h00;
        end
        else if (armed_r && sck_rise)
        begin
            // Count wraps from 63 back to 32 so every later byte still lands
            // on a multiple of eight; only the low three bits matter past the header.
            shift_r <= shift_nxt;
            bit_cnt_r <= (bit_cnt_r == 6'h3f) ? 6'h20 : bits_in;
            // Opcode taken MSB first after eight bits.
            if (bits_in == 6'h08)
                opcode_r <= shift_nxt;
            // Address bytes follow the opcode; the top nibble is dropped later.
            if (bits_in == 6'h10 || bits_in == 6'h18)
                addr_r <= {addr_r[7:0], shift_nxt};
            // Status streams out at any time, busy or not.
            if (bits_in[2:0] == 3'h0 && bits_in == 6'h08 && shift_nxt == `OP_READ_STATUS)
                out_byte_r <= status_now;
            else if (bits_in[2:0] == 3'h0 && opcode_r == `OP_READ_STATUS)
                out_byte_r <= status_now;
        end
        else if (armed_r && sck_fall && bit_cnt_r >= 6'h08 && opcode_r == `OP_READ_STATUS)
        begin
            // Data out changes after the falling edge of SCK.
            // The first bit appears after the first falling clock of the data byte.
            sdo_oe_n_r <= 1'b0;
            sdo_r <= out_byte_r[3'h7 - 3'(bit_cnt_r[2:0])];
        end
    end

    // Latch, status bits and the self-timed write cycle.
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            // Latch clear at power-up; protect bits stand for stored values.
            latch_r <= 1'b0;
            busy_r <= 1'b0;
            pin_en_r <= 1'b0;
            bp_hi_r <= 1'b0;
            bp_lo_r <= 1'b0;
            timer_r <= 32'h0;
            array_write_r <= 1'b0;
            array_addr_r <= '0;
        end
        else
        begin
            // Start pulse stands for one cycle only.
            array_write_r <= 1'b0;
            if (busy_r)
            begin
                // Cycle runs to its end regardless of the protect pin.
                // Array commands are ignored until then.
                if (timer_r == 32'h1)
                begin
                    // Busy and latch clear together at cycle end.
                    busy_r <= 1'b0;
                    // Latch cleared after a completed write.
                    latch_r <= 1'b0;
                end
                // Counter reaches zero as busy drops and then rests.
                timer_r <= timer_r - 32'h1;
                // The set-latch command still works while busy or protected; clear-latch is dropped while busy.
                if (cs_rise && armed_r && bit_cnt_r == 6'h08 && opcode_r == `OP_SET_LATCH)
                    latch_r <= 1'b1;
            end
            else if (cs_rise && armed_r)
            begin
                // Latch commands complete on select rising after eight bits.
                if (bit_cnt_r == 6'h08 && opcode_r == `OP_SET_LATCH)
                    latch_r <= 1'b1;
                else if (bit_cnt_r == 6'h08 && opcode_r == `OP_CLR_LATCH)
                    latch_r <= 1'b0;
                // Writes begin only with the latch set.
                else if (stat_wr_go || arr_wr_go)
                begin
                    // Busy sets as the internal write begins.
                    busy_r <= 1'b1;
                    timer_r <= WRITE_CYCLE_CLKS;
                    if (stat_wr_go)
                    begin
                        // Only the nonvolatile bits take new values.
                        pin_en_r <= shift_r[`SR_PIN_EN_BIT];
                        bp_hi_r <= shift_r[`SR_BP_HI_BIT];
                        bp_lo_r <= shift_r[`SR_BP_LO_BIT];
                    end
                    else
                    begin
                        array_write_r <= 1'b1;
                        array_addr_r <= addr_r[`ADDR_BITS-1:0];
                    end
                end
            end
        end
    end

    // Registered status view; busy and latch are not writable.
    // One register stage keeps o_status glitch free; it trails the live bits by one cycle.
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            status_r <= 8'h00;
        else
            status_r <= status_now;
    end

    // Every output is taken directly from a flip-flop.
    // Nothing combinational reaches a pin of this block.
    assign o_sdo = sdo_r;
    assign o_sdo_oe_n = sdo_oe_n_r;
    assign o_array_write = array_write_r;
    assign o_array_addr = array_addr_r;
    assign o_status = status_r;
endmodule : serial_eeprom_write_protect

// File: tb/spi_host_model.sv
// Behavioural SPI host that frames commands for the protection block.
module spi_host_model (
    // Clock.
    input wire logic i_clk,
    // Bus to the device.
    output logic o_cs_n,
    output logic o_sck,
    output logic o_sdi,
    input wire logic i_sdo
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rd_byte = 8'h00;
    initial
    begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_sdi = 1'b0;
    end
    // MSB first, select raised after the last bit.
    // Half is the clock phase in cycles; a larger value models a slow host.
    task automatic send(input logic [31:0] v, input int n, input int half);
        @(posedge i_clk) o_cs_n <= 1'b0;
        repeat (half) @(posedge i_clk);
        for (int i = n - 1; i >= 0; i--)
        begin
            o_sck <= 1'b0;
            o_sdi <= v[i];
            repeat (half) @(posedge i_clk);
            rd_byte <= {rd_byte[6:0], i_sdo};
            o_sck <= 1'b1;
            repeat (half) @(posedge i_clk);
        end
        o_sck <= 1'b0;
        repeat (half) @(posedge i_clk);
        o_cs_n <= 1'b1;
        repeat (8) @(posedge i_clk);
        o_sdi <= ~o_sdi; // The line is not idle-held, so stale data must not look valid.
    endtask : send
endmodule : spi_host_model

// File: tb/serial_eeprom_write_protect_props.sv
// Property checker for the serial EEPROM write-protection block.
`include "eeprom_protect_regs.svh"
module serial_eeprom_write_protect_props #(
    parameter int unsigned WRITE_CYCLE_CLKS = 50
)
(
    // Clock, reset and pins.
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_cs_n,
    // Outputs watched.
    input wire logic o_sdo_oe_n,
    input wire logic o_array_write,
    input wire logic [`ADDR_BITS-1:0] o_array_addr,
    input wire logic [7:0] o_status
);
    int unsigned busy_cnt;
    // Counts the length of one write cycle so it can be judged at its end.
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            busy_cnt <= 0;
        else
            busy_cnt <= o_status[0] ? busy_cnt + 1 : 0;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    AST_UNUSED_ZERO: assert property (o_status[6:4] == 3'b000) else $error("unused bits set");
    AST_LATCH_ON_RISE: assert property ($rose(o_status[1]) |-> i_cs_n) else $error("latch set in frame");
    AST_WRITE_NEEDS_LATCH: assert property (o_array_write |-> $past(o_status[1])) else $error("write w/o latch");
    AST_BUSY_ON_RISE: assert property ($rose(o_status[0]) |-> i_cs_n) else $error("busy in frame");
    AST_BUSY_LENGTH: assert property ($fell(o_status[0]) |-> busy_cnt >= WRITE_CYCLE_CLKS - 2
        && busy_cnt <= WRITE_CYCLE_CLKS + 2) else $error("bad cycle length");
    AST_LATCH_AT_END: assert property ($fell(o_status[0]) |-> !o_status[1]) else $error("latch kept");
    AST_SDO_IDLE: assert property (i_cs_n [*8] |-> o_sdo_oe_n) else $error("output driven idle");
    AST_NV_ONLY_WRITE: assert property ($changed({o_status[7], o_status[3:2]}) |-> ##[0:2] o_status[0])
        else $error("protect bits moved");
    AST_NO_WRITE_BUSY: assert property (o_array_write |-> !$past(o_status[0], 2)) else $error("write in busy");
    AST_BLOCK_LOCK: assert property (o_array_write |-> o_status[3:2] == 2'b00
        || (o_status[3:2] == 2'b01 && o_array_addr < 12'hc00) || (o_status[3:2] == 2'b10 && o_array_addr < 12'h800))
        else $error("locked block written");
    cover property (o_array_write);
    cover property ($fell(o_status[0]));
    cover property (!o_sdo_oe_n);
endmodule : serial_eeprom_write_protect_props
bind serial_eeprom_write_protect serial_eeprom_write_protect_props #(
    .WRITE_CYCLE_CLKS(WRITE_CYCLE_CLKS)
) props_inst (
    .i_clk(i_clk), .i_reset(i_reset), .i_cs_n(i_cs_n), .o_sdo_oe_n(o_sdo_oe_n),
    .o_array_write(o_array_write), .o_array_addr(o_array_addr), .o_status(o_status)
);

// File: tb/testbench.sv
// Self-checking bench for the serial EEPROM write-protection block.
`include "eeprom_protect_regs.svh"
`define CHK(nm, e, g) checked++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %s exp %h got %h", nm, e, g); end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned CYC = 400;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic wp_n = 1'b1;
    logic cs_n, sck, sdi, sdo, sdo_oe_n, arr_wr;
    logic [11:0] arr_addr;
    logic [11:0] last_addr = 12'h000;
    logic [7:0] status;
    int n_errors = 0;
    int checked = 0;
    int pulses = 0;
    always #12.5 clk = ~clk;
    serial_eeprom_write_protect #(.WRITE_CYCLE_CLKS(CYC)) uut (.i_clk(clk), .i_reset(reset), .i_cs_n(cs_n),
        .i_sck(sck), .i_sdi(sdi), .i_write_protect_n(wp_n), .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n),
        .o_array_write(arr_wr), .o_array_addr(arr_addr), .o_status(status));
    spi_host_model host (.i_clk(clk), .o_cs_n(cs_n), .o_sck(sck), .o_sdi(sdi), .i_sdo(sdo_oe_n ? 1'b1 : sdo));
    // Records every write start; the pulse stands one cycle only.
    always @(posedge clk)
        if (arr_wr === 1'b1)
        begin
            pulses++;
            last_addr = arr_addr;
        end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
    task automatic cmd(input logic [7:0] op);
        host.send({24'h0, op}, 8, 4);
    endtask : cmd
    task automatic write_status_cmd(input logic [7:0] d);
        cmd(`OP_SET_LATCH);
        host.send({16'h0, `OP_WRITE_STATUS, d}, 16, 4);
    endtask : write_status_cmd
    task automatic wait_idle();
        int k;
        k = 0;
        while (status[0] !== 1'b0 && k < 2000)
        begin
            @(posedge clk);
            k++;
        end
        `CHK("idle", 1'b1, k < 2000) // cycle ends
    endtask : wait_idle
    task automatic t_latch();
        `CHK("power-up oe_n", 1'b1, sdo_oe_n) // released
        `CHK("power-up status", 8'h00, status) // clear
        cmd(`OP_SET_LATCH);
        `CHK("set latch", 8'h02, status) // set
        cmd(`OP_CLR_LATCH);
        `CHK("clear latch", 8'h00, status) // cleared
        $display("test latch done");
    endtask : t_latch
    task automatic t_status();
        write_status_cmd(8'hff);
        `CHK("busy write", 8'h8f, status) // busy view
        wp_n <= 1'b0;
        host.send({16'h0, `OP_READ_STATUS, 8'h00}, 16, 6);
        `CHK("read in busy", 8'h8f, host.rd_byte) // read
        wait_idle();
        `CHK("after write", 8'h8c, status) // done
        cmd(`OP_SET_LATCH);
        `CHK("latch locked", 8'h8e, status) // latch works
        host.send({16'h0, `OP_WRITE_STATUS, 8'h00}, 16, 4);
        `CHK("refused", 8'h8e, status) // refused
        cmd(`OP_CLR_LATCH);
        `CHK("clear locked", 8'h8c, status) // clears
        wp_n <= 1'b1;
        write_status_cmd(8'h00);
        wait_idle();
        `CHK("unlocked", 8'h00, status) // writable
        host.send({16'h0, `OP_WRITE_STATUS, 8'h8c}, 16, 4);
        `CHK("no latch", 8'h00, status) // locked
        $display("test status done");
    endtask : t_status
    task automatic t_array();
        logic [11:0] addrs [4] = '{12'h7ff, 12'h800, 12'hbff, 12'hc00};
        logic ok;
        int p;
        wp_n <= 1'b0;
        for (int b = 0; b < 4; b++)
        begin
            write_status_cmd({4'h0, b[1:0], 2'b00});
            wait_idle();
            `CHK("protect bits", {4'h0, b[1:0], 2'b00}, status) // stored
            for (int j = 0; j < 4; j++)
            begin
                ok = !(b == 3 || (b == 2 && addrs[j] >= 12'h800) || (b == 1 && addrs[j] >= 12'hc00));
                p = pulses;
                cmd(`OP_SET_LATCH);
                host.send({`OP_ARRAY_WRITE, 4'ha, addrs[j], 8'h5a}, 32, 4);
                wait_idle();
                `CHK("write start", ok, pulses == p + 1) // levels
                `CHK("addr", addrs[j], ok ? last_addr : addrs[j]) // address
                cmd(`OP_CLR_LATCH);
            end
        end
        $display("test array done");
    endtask : t_array
    task automatic t_refuse();
        int p;
        write_status_cmd(8'h00);
        wait_idle();
        p = pulses;
        host.send({`OP_ARRAY_WRITE, 16'h0100, 8'h11}, 32, 4);
        cmd(`OP_SET_LATCH);
        host.send({4'h0, `OP_ARRAY_WRITE, 16'h0100, 4'h5}, 28, 6);
        `CHK("refused starts", p, pulses) // no start
        host.send({`OP_ARRAY_WRITE, 16'h0200, 8'h11}, 32, 4);
        host.send({`OP_ARRAY_WRITE, 16'h0300, 8'h22}, 32, 4);
        wait_idle();
        `CHK("one start", p + 1, pulses) // ignored
        `CHK("kept addr", 12'h200, last_addr) // first kept
        $display("test refuse done");
    endtask : t_refuse
    // Main sequence after a four-cycle reset.
    initial
    begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        t_latch();
        t_status();
        t_array();
        t_refuse();
        final_report();
    end
    // Watchdog: the tests need about 17000 cycles.
    initial
    begin
        repeat (60000) @(posedge clk);
        n_errors++;
        final_report();
    end
endmodule : testbench
